/* verilog/dshi_top.v */
// serial host interface: clocked-serial and two-wire receive front end
`timescale 1ns/100ps
`include "dshi_regs.vh"
// Functional notes
// - frame is 24 bits msb first: toggle, rw, pad, channel, target, payload
// - toggle bit picks bank a or b when toggle mode is on
// - payload goes to target register of the addressed channel
// - target 11 data, 10 offset, 01 gain, 00 special function
// - interface select high runs clocked serial, low runs two-wire bus
// - chain enable low gives standalone mode, any clock style
// - sync falling edge starts frame and clears bit counter
// - standalone ignores other sync edges and clocks after 24 bits
// - chain mode shifts every clock while sync is low
// - chain mode shifts old bits out, updated on clock rising edge
// - sync rising edge latches the frame and stops shifting
// - sync rising before 24 clocks discards the frame
// - read bit set selects a register for readback
// - next frame returns 10 address bits then 14 register bits
// - readback changes on rising clock, first bit at sync fall
// - two-wire mode is slave only, never drives bus clock
// - slave address is 10101 then the two address pins
// - idle waits for start and matching address
// - start is sda fall with scl high, stop sda rise
// - matching address with write bit low and data bytes get ack in ninth clock
module dshi_top #(
  parameter CHANNELS = 16,
  parameter PAY_W    = 14
) (
  input  wire        CORE_CLK,
  input  wire        NRST,
  input  wire        IF_SELECT,
  input  wire        CHAIN_ENABLE_PIN,
  input  wire        TOGGLE_MODE,
  input  wire        SYNC_N,
  input  wire        SCLK,
  input  wire        DIN,
  output reg         SERIAL_DATA_OUT,
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE_N,
  input  wire        BUS_ADDR_PIN_HI,
  input  wire        BUS_ADDR_PIN_LO,
  output reg         FRAME_VALID,
  output reg  [23:0] FRAME_DATA,
  input  wire        FRAME_READY,
  output reg         WR_STROBE,
  output reg  [1:0]  WR_TARGET,
  output reg  [3:0]  WR_CHANNEL,
  output reg         WR_BANK_B,
  output reg  [13:0] WR_PAYLOAD,
  output reg         FRAME_BAD,
  output reg         BUS_BYTE_VALID,
  output reg  [7:0]  BUS_BYTE
);
  // three-stage samplers: a change counts once stages two and three agree
  reg [2:0] sync_s_reg, sclk_s_reg, din_s_reg, scl_s_reg, sda_s_reg;
  reg       sync_reg, sclk_reg, din_reg, scl_reg, sda_reg;
  // sclk resets low; a false rise after reset meets an idle receiver and does nothing
  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      sync_s_reg <= 3'h7;
      sclk_s_reg <= 3'h0;
      din_s_reg  <= 3'h0;
      scl_s_reg  <= 3'h7;
      sda_s_reg  <= 3'h7;
      sync_reg   <= 1'b1;
      sclk_reg   <= 1'b0;
      din_reg    <= 1'b0;
      scl_reg    <= 1'b1;
      sda_reg    <= 1'b1;
    end else begin
      sync_s_reg <= {sync_s_reg[1:0], SYNC_N};
      sclk_s_reg <= {sclk_s_reg[1:0], SCLK};
      din_s_reg  <= {din_s_reg[1:0], DIN};
      scl_s_reg  <= {scl_s_reg[1:0], SCL_IN};
      sda_s_reg  <= {sda_s_reg[1:0], SDA_IN};
      if (sync_s_reg[1] == sync_s_reg[2]) sync_reg <= sync_s_reg[2];
      if (sclk_s_reg[1] == sclk_s_reg[2]) sclk_reg <= sclk_s_reg[2];
      if (din_s_reg[1] == din_s_reg[2]) din_reg <= din_s_reg[2];
      if (scl_s_reg[1] == scl_s_reg[2]) scl_reg <= scl_s_reg[2];
      if (sda_s_reg[1] == sda_s_reg[2]) sda_reg <= sda_s_reg[2];
    end
  end

  wire spi_mode  = IF_SELECT;
  // edges come from the filtered level, so a single odd sample never counts
  wire sync_fall = sync_reg & (sync_s_reg[1] == sync_s_reg[2]) & ~sync_s_reg[2];
  wire sync_rise = ~sync_reg & (sync_s_reg[1] == sync_s_reg[2]) & sync_s_reg[2];
  wire sclk_fall = sclk_reg & (sclk_s_reg[1] == sclk_s_reg[2]) & ~sclk_s_reg[2];
  wire sclk_rise = ~sclk_reg & (sclk_s_reg[1] == sclk_s_reg[2]) & sclk_s_reg[2];

  // per-channel register copies so readback has something real to return
  reg [PAY_W-1:0] data_a_mem [0:CHANNELS-1];
  reg [PAY_W-1:0] data_b_mem [0:CHANNELS-1];
  reg [PAY_W-1:0] offs_mem   [0:CHANNELS-1];
  reg [PAY_W-1:0] gain_mem   [0:CHANNELS-1];

  function [PAY_W-1:0] read_sel;
    input [1:0] tgt;
    input [3:0] ch;
    input       bank;
    begin
      case (tgt)
        `DSHI_TGT_DATA:   read_sel = bank ? data_b_mem[ch] : data_a_mem[ch];
        `DSHI_TGT_OFFSET: read_sel = offs_mem[ch];
        `DSHI_TGT_GAIN:   read_sel = gain_mem[ch];
        default:          read_sel = {PAY_W{1'b0}};
      endcase
    end
  endfunction

  // clocked-serial receiver
  reg [23:0]           shift_reg;
  reg [`DSHI_CNT_W-1:0] cnt_reg;
  reg                  active_reg;
  reg [23:0]           out_sr_reg;
  reg                  rd_pend_reg;
  reg [23:0]           rd_word_reg;
  reg                  push_reg;
  reg [23:0]           push_data_reg;
  // the count saturates so a long continuous clock cannot wrap into a short frame
  wire                 full_cnt = (cnt_reg == `DSHI_CNT_FULL);
  wire                 chain    = CHAIN_ENABLE_PIN;
  wire                 take_bit = active_reg & ~sync_reg & sclk_fall
                                  & (chain | ~full_cnt);

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      shift_reg       <= 24'h000000;
      cnt_reg         <= {`DSHI_CNT_W{1'b0}};
      active_reg      <= 1'b0;
      out_sr_reg      <= 24'h000000;
      rd_pend_reg     <= 1'b0;
      rd_word_reg     <= 24'h000000;
      push_reg        <= 1'b0;
      push_data_reg   <= 24'h000000;
      FRAME_BAD       <= 1'b0;
      SERIAL_DATA_OUT <= 1'b0;
    end else begin
      push_reg  <= 1'b0;
      FRAME_BAD <= 1'b0;
      if (spi_mode && sync_fall) begin
        active_reg <= 1'b1;
        cnt_reg    <= {`DSHI_CNT_W{1'b0}};
        if (rd_pend_reg) begin
          // first readback bit appears at the sync fall
          out_sr_reg      <= rd_word_reg;
          SERIAL_DATA_OUT <= rd_word_reg[23];
        end else begin
          out_sr_reg      <= shift_reg;
          SERIAL_DATA_OUT <= chain & shift_reg[23];
        end
      end else if (spi_mode && sync_rise && active_reg) begin
        active_reg <= 1'b0;
        if (cnt_reg < `DSHI_CNT_FULL) begin
          FRAME_BAD <= 1'b1;
        end else begin
          push_reg      <= 1'b1;
          push_data_reg <= shift_reg;
          // every full frame rearms or clears readback, which then holds until the next full frame
          rd_pend_reg   <= shift_reg[`DSHI_BIT_RW];
          // with toggle mode on, the request's bank bit picks which data copy comes back; otherwise bank a
          rd_word_reg   <= {shift_reg[`DSHI_ECHO_HI:`DSHI_ECHO_LO],
                            read_sel(shift_reg[`DSHI_TS_HI:`DSHI_TS_LO],
                                     shift_reg[`DSHI_CH_HI:`DSHI_CH_LO],
                                     TOGGLE_MODE & shift_reg[`DSHI_BIT_TOGGLE])};
        end
      end else if (!spi_mode) begin
        // leaving clocked-serial mode abandons a frame in flight
        active_reg      <= 1'b0;
        SERIAL_DATA_OUT <= 1'b0;
      end else begin
        if (take_bit) begin
          shift_reg  <= {shift_reg[22:0], din_reg};
          // in chain mode old bits leave first, then this frame's own bits follow
          out_sr_reg <= {out_sr_reg[22:0], din_reg};
          if (!full_cnt) cnt_reg <= cnt_reg + 1'b1;
        end
        // output moves on the rising clock so it is steady at the falling one
        if (active_reg && !sync_reg && sclk_rise && (chain || rd_pend_reg)) begin
          SERIAL_DATA_OUT <= out_sr_reg[23];
        end
      end
    end
  end

  // two-wire slave receiver
  localparam BS_IDLE = 4'h1;
  localparam BS_ADDR = 4'h2;
  localparam BS_DATA = 4'h4;
  localparam BS_ACK  = 4'h8;
  reg [3:0] bs_reg;
  reg [3:0] bcnt_reg;
  reg [7:0] bsh_reg;
  reg       was_addr_reg;
  wire      scl_stable = (scl_s_reg[1] == scl_s_reg[2]);
  wire      scl_rise   = ~scl_reg & scl_stable & scl_s_reg[2];
  wire      scl_fall   = scl_reg & scl_stable & ~scl_s_reg[2];
  wire      sda_stable = (sda_s_reg[1] == sda_s_reg[2]);
  // a start in any state restarts address collection, which covers repeated starts
  wire      bus_start  = scl_reg & sda_reg & sda_stable & ~sda_s_reg[2];
  wire      bus_stop   = scl_reg & ~sda_reg & sda_stable & sda_s_reg[2];
  wire [6:0] my_addr   = {`DSHI_SLAVE_FIXED, BUS_ADDR_PIN_HI, BUS_ADDR_PIN_LO};

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      bs_reg         <= BS_IDLE;
      bcnt_reg       <= 4'h0;
      bsh_reg        <= 8'h00;
      was_addr_reg   <= 1'b0;
      SDA_OUT        <= 1'b1;
      SDA_OE_N       <= 1'b1;
      BUS_BYTE_VALID <= 1'b0;
      BUS_BYTE       <= 8'h00;
    end else begin
      BUS_BYTE_VALID <= 1'b0;
      SDA_OUT        <= 1'b0; // only low is ever driven; scl is never driven
      if (spi_mode || bus_stop) begin
        bs_reg   <= BS_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (bus_start) begin
        bs_reg   <= BS_ADDR;
        bcnt_reg <= 4'h0;
        SDA_OE_N <= 1'b1;
      end else begin
        case (bs_reg)
          BS_IDLE: SDA_OE_N <= 1'b1;
          BS_ADDR, BS_DATA: begin
            if (scl_rise) begin
              bsh_reg  <= {bsh_reg[6:0], sda_reg};
              bcnt_reg <= bcnt_reg + 1'b1;
            end
            if (scl_fall && bcnt_reg == `DSHI_BUS_BITS) begin
              if (bs_reg == BS_ADDR && (bsh_reg[7:1] != my_addr || bsh_reg[0])) begin
                bs_reg <= BS_IDLE;
              end else begin
                SDA_OE_N     <= 1'b0;
                was_addr_reg <= (bs_reg == BS_ADDR);
                bs_reg       <= BS_ACK;
                if (bs_reg == BS_DATA) begin
                  BUS_BYTE_VALID <= 1'b1;
                  BUS_BYTE       <= bsh_reg;
                end
              end
            end
          end
          // the ack is let go on the ninth falling scl, or at once whenever clocked-serial mode is selected
          BS_ACK: begin
            if (scl_fall) begin
              SDA_OE_N <= 1'b1;
              bcnt_reg <= 4'h0;
              bs_reg   <= BS_DATA;
            end
          end
          default: bs_reg <= BS_IDLE;
        endcase
      end
    end
  end

  // frame queue towards the register writer
  wire        q_in_ready;
  wire        q_valid;
  wire [23:0] q_data;
  reg         q_pop;
  // a full queue drops the newest frame; the host side sees no refusal
  wire        q_push = push_reg & q_in_ready;
  // fields of the frame at the queue head
  wire [3:0]       q_ch   = q_data[`DSHI_CH_HI:`DSHI_CH_LO];
  wire [1:0]       q_tgt  = q_data[`DSHI_TS_HI:`DSHI_TS_LO];
  wire [PAY_W-1:0] q_pay  = q_data[`DSHI_PAY_HI:0];
  wire             q_bank = TOGGLE_MODE & q_data[`DSHI_BIT_TOGGLE];
  dshi_fifo #(
    .WIDTH (24),
    .DEPTH (`DSHI_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (CORE_CLK),
    .nrst      (NRST),
    .in_valid  (q_push),
    .in_ready  (q_in_ready),
    .in_data   (push_data_reg),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  // writer: frames with the read bit set update nothing
  integer i;
  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      q_pop       <= 1'b0;
      FRAME_VALID <= 1'b0;
      FRAME_DATA  <= 24'h000000;
      WR_STROBE   <= 1'b0;
      WR_TARGET   <= 2'h0;
      WR_CHANNEL  <= 4'h0;
      WR_BANK_B   <= 1'b0;
      WR_PAYLOAD  <= 14'h0000;
      for (i = 0; i < CHANNELS; i = i + 1) begin
        data_a_mem[i] <= {PAY_W{1'b0}};
        data_b_mem[i] <= {PAY_W{1'b0}};
        offs_mem[i]   <= {PAY_W{1'b0}};
        gain_mem[i]   <= {PAY_W{1'b0}};
      end
    end else begin
      q_pop       <= 1'b0;
      WR_STROBE   <= 1'b0;
      FRAME_VALID <= q_valid & ~q_pop;
      FRAME_DATA  <= q_data;
      if (q_valid && !q_pop && FRAME_READY) begin
        q_pop <= 1'b1;
        if (!q_data[`DSHI_BIT_RW]) begin
          // special function frames strobe too, so a decoder outside can act on them
          WR_STROBE  <= 1'b1;
          WR_TARGET  <= q_tgt;
          WR_CHANNEL <= q_ch;
          WR_BANK_B  <= q_bank;
          WR_PAYLOAD <= q_pay;
          case (q_tgt)
            `DSHI_TGT_DATA: begin
              if (q_bank) begin
                data_b_mem[q_ch] <= q_pay;
              end else begin
                data_a_mem[q_ch] <= q_pay;
              end
            end
            `DSHI_TGT_OFFSET: offs_mem[q_ch] <= q_pay;
            `DSHI_TGT_GAIN:   gain_mem[q_ch] <= q_pay;
            default: ;
          endcase
        end
      end
    end
  end
endmodule // dshi_top

/* verilog/dshi_regs.vh */
// constants for the converter host serial interface
`ifndef DSHI_REGS_VH
`define DSHI_REGS_VH
`define DSHI_FRAME_BITS     24
`define DSHI_CNT_W          5
`define DSHI_CNT_FULL       5'h18
`define DSHI_BIT_TOGGLE     23
`define DSHI_BIT_RW         22
`define DSHI_CH_HI          19
`define DSHI_CH_LO          16
`define DSHI_TS_HI          15
`define DSHI_TS_LO          14
`define DSHI_PAY_HI         13
`define DSHI_ECHO_HI        23
`define DSHI_ECHO_LO        14
`define DSHI_TGT_DATA       2'h3
`define DSHI_TGT_OFFSET     2'h2
`define DSHI_TGT_GAIN       2'h1
`define DSHI_TGT_SFR        2'h0
`define DSHI_SLAVE_FIXED    5'h15
`define DSHI_BUS_BITS       4'h8
`define DSHI_BUS_ACK_BIT    4'h9
`define DSHI_FIFO_DEPTH     8
`endif

/* verilog/dshi_fifo.v */
// small synchronous valid/ready fifo for received command frames
`timescale 1ns/100ps
module dshi_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_reg;
  reg [AW:0]      rd_reg;
  wire            full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire            empty = (wr_reg == rd_reg);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_reg[AW-1:0]];
  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (!nrst) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule // dshi_fifo

/* testbench/dshi_checker.sv */
// port assertions for the serial host interface
`timescale 1ns/100ps
module dshi_checker (
  input wire        CORE_CLK,
  input wire        NRST,
  input wire        IF_SELECT,
  input wire        TOGGLE_MODE,
  input wire        SDA_OUT,
  input wire        SDA_OE_N,
  input wire        FRAME_VALID,
  input wire [23:0] FRAME_DATA,
  input wire        FRAME_READY,
  input wire        WR_STROBE,
  input wire [1:0]  WR_TARGET,
  input wire        WR_BANK_B,
  input wire        FRAME_BAD,
  input wire        BUS_BYTE_VALID
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  chk_write_pulse_one: assert property (WR_STROBE |=> !WR_STROBE)
    else $error("write strobe held");
  chk_pop_gives_write: assert property (FRAME_VALID && FRAME_READY && !FRAME_DATA[22]
    |-> ##[0:2] WR_STROBE) else $error("queued write lost");
  chk_bank_a_only: assert property (WR_STROBE && !TOGGLE_MODE |-> !WR_BANK_B)
    else $error("bank b without toggle mode");
  chk_target_follows: assert property (WR_STROBE |-> WR_TARGET == FRAME_DATA[15:14]
    && !FRAME_DATA[22]) else $error("write target differs from its frame");
  chk_bad_pulse: assert property (FRAME_BAD |=> !FRAME_BAD)
    else $error("bad frame flag held");
  chk_serial_no_ack: assert property (IF_SELECT && $past(IF_SELECT) |-> SDA_OE_N)
    else $error("ack in clocked serial mode");
  chk_byte_bus_only: assert property (BUS_BYTE_VALID |-> !IF_SELECT)
    else $error("bus byte in clocked serial mode");
  chk_byte_acked: assert property (BUS_BYTE_VALID |-> ##[0:2] !SDA_OE_N)
    else $error("bus byte without ack");
  chk_ack_drive_low: assert property (!SDA_OE_N |-> !SDA_OUT)
    else $error("sda driven high");
  chk_ack_span_min: assert property ($fell(SDA_OE_N) |=> !SDA_OE_N [*8])
    else $error("ack too short");
  chk_ack_span_max: assert property (!SDA_OE_N |-> ##[1:60] SDA_OE_N)
    else $error("ack not released");
  cov_write: cover property (WR_STROBE && WR_BANK_B);
  cov_bad: cover property (FRAME_BAD);
  cov_byte: cover property (BUS_BYTE_VALID);
endmodule // dshi_checker

/* testbench/dshi_host.sv */
// host model: serial frame master and two-wire bus master
`timescale 1ns/100ps
module dshi_host (
  input  wire clk,
  input  wire serial_data_out,
  input  wire sda_bus,
  output reg  sync_n,
  output reg  sclk,
  output reg  din,
  output reg  scl,
  output reg  sda
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    scl = 1'b1;
    sda = 1'b1;
  end
  // ten core cycles per phase keeps the link clock at 160 ns
  task half;
    repeat (10) @(negedge clk);
  endtask
  // exactly n clocks, sync rises only after the last one
  task frame(input [47:0] w, input integer n, output [47:0] rd);
    integer i;
    begin
      rd = 48'h0;
      sync_n = 1'b0;
      half;
      for (i = 0; i < n; i = i + 1) begin
        din = w[47-i];
        half;
        rd = {rd[46:0], serial_data_out};
        sclk = 1'b0;
        half;
        sclk = 1'b1;
      end
      half;
      sync_n = 1'b1;
      din = ~din;
      half;
    end
  endtask
  // a=1 start, a=0 stop
  task bus_cond(input a);
    begin
      half;
      sda = a;
      half;
      scl = 1'b1;
      half;
      sda = ~a;
      half;
      if (a) scl = 1'b0;
    end
  endtask
  // sda only moves while scl is low; the ninth bit releases for the ack
  task put_byte(input [8:0] b, output ack);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        half;
        sda = b[i];
        half;
        scl = 1'b1;
        half;
        ack = ~sda_bus;
        scl = 1'b0;
      end
    end
  endtask
endmodule // dshi_host

/* testbench/tb.sv */
// self-checking bench for the serial host interface
`timescale 1ns/100ps
module tb;
  reg          clk = 1'b0, nrst = 1'b0, if_sel = 1'b1, chain = 1'b0, toggle = 1'b0;
  reg          ready = 1'b1, ack;
  reg  [23:0]  w;
  reg  [47:0]  rd;
  reg  [20:0]  wr_last = 21'h0;
  reg  [7:0]   byte_last = 8'h0;
  wire         sync_n, sclk, din, serial_data_out, scl, sda_h, oe_n, sda_o, fvalid, wr, bad, bvalid;
  wire         bank;
  wire [23:0]  fdata;
  wire [1:0]   tgt;
  wire [3:0]   ch;
  wire [13:0]  pay;
  wire [7:0]   bbyte;
  wire         sda_bus = sda_h & (oe_n | sda_o);
  integer      errors = 0, comparisons = 0, wr_cnt = 0, bad_cnt = 0, i, w0;
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    if (wr) wr_cnt <= wr_cnt + 1;
    if (wr) wr_last <= {bank, ch, tgt, pay};
    if (bad) bad_cnt <= bad_cnt + 1;
    if (bvalid) byte_last <= bbyte;
  end
  dshi_top dshi_top_i (.CORE_CLK(clk), .NRST(nrst), .IF_SELECT(if_sel),
    .CHAIN_ENABLE_PIN(chain), .TOGGLE_MODE(toggle), .SYNC_N(sync_n), .SCLK(sclk), .DIN(din),
    .SERIAL_DATA_OUT(serial_data_out), .SCL_IN(scl), .SDA_IN(sda_bus), .SDA_OUT(sda_o), .SDA_OE_N(oe_n),
    .BUS_ADDR_PIN_HI(1'b1), .BUS_ADDR_PIN_LO(1'b0), .FRAME_VALID(fvalid), .FRAME_DATA(fdata),
    .FRAME_READY(ready), .WR_STROBE(wr), .WR_TARGET(tgt), .WR_CHANNEL(ch), .WR_BANK_B(bank),
    .WR_PAYLOAD(pay), .FRAME_BAD(bad), .BUS_BYTE_VALID(bvalid), .BUS_BYTE(bbyte));
  dshi_host dshi_host_i (.clk(clk), .serial_data_out(serial_data_out), .sda_bus(sda_bus), .sync_n(sync_n),
    .sclk(sclk), .din(din), .scl(scl), .sda(sda_h));
  task print_verdict;
    begin
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp, input [8*10:1] what);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: %0s is %h", $time, what, got);
      end
    end
  endtask
  // send a frame and wait, bounded, for dw write strobes
  task xfer(input [47:0] f, input integer n, input integer dw);
    integer k;
    begin
      w0 = wr_cnt;
      dshi_host_i.frame(f, n, rd);
      for (k = 0; k < 60 && wr_cnt < w0 + dw; k = k + 1) @(negedge clk);
      if (dw == 0) repeat (60) @(negedge clk);
      check(wr_cnt - w0, dw, "writes");
      if (k == 60) print_verdict;
    end
  endtask
  task wr_chk(input [23:0] f);
    check(wr_last, {toggle & f[23], f[19:16], f[15:14], f[13:0]}, "fields");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    for (i = 0; i < 4; i = i + 1) begin
      w = {2'b10, 2'h0, i[3:0], i[1:0], 14'h3A5C};
      xfer({w, 24'h0}, 24, 1);
      wr_chk(w);
    end
    toggle = 1'b1;
    xfer({24'h8B7FFF, 24'h0}, 24, 1);
    wr_chk(24'h8B7FFF);
    toggle = 1'b0;
    dshi_host_i.frame({24'hC3C001, 24'h0}, 10, rd);
    xfer({24'h83C002, 24'h0}, 24, 1);
    check(bad_cnt, 1, "bad");
    wr_chk(24'h83C002);
    xfer({24'h034ABC, 24'h0}, 24, 1);
    xfer({24'h434000, 24'h0}, 24, 0);
    xfer(48'h0, 24, 1);
    check(rd[23:0], {10'h10D, 14'h0ABC}, "readback");
    chain = 1'b1;
    xfer({24'h8C3123, 24'h0FD555}, 48, 1);
    check(rd[23:0], 24'h8C3123, "chain out");
    wr_chk(24'h0FD555);
    chain = 1'b0;
    ready = 1'b0;
    for (i = 0; i < 9; i = i + 1) begin
      xfer({4'h0, i[3:0], 2'h3, 10'h0, i[3:0], 24'h0}, 24, 0);
    end
    check({fvalid, fdata}, {1'b1, 24'h00C000}, "queue head");
    ready = 1'b1;
    repeat (200) @(negedge clk);
    check(wr_cnt - w0, 8, "drained");
    wr_chk(24'h07C007);
    check(fvalid, 0, "empty");
    for (i = 0; i < 4; i = i + 1) begin
      if_sel = (i == 3);
      dshi_host_i.bus_cond(1'b1);
      dshi_host_i.put_byte({6'h2B, i == 1, i == 2, 1'b1}, ack);
      check(ack, i == 0, "addr ack");
      if (i == 0) dshi_host_i.put_byte(9'h0B5, ack);
      if (i == 0) check({ack, byte_last}, 9'h15A, "bus byte");
      dshi_host_i.bus_cond(1'b0);
    end
    print_verdict;
  end
endmodule // tb
bind dshi_top dshi_checker dshi_checker_i (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .IF_SELECT(IF_SELECT), .TOGGLE_MODE(TOGGLE_MODE), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .FRAME_VALID(FRAME_VALID), .FRAME_DATA(FRAME_DATA), .FRAME_READY(FRAME_READY),
  .WR_STROBE(WR_STROBE), .WR_TARGET(WR_TARGET), .WR_BANK_B(WR_BANK_B),
  .FRAME_BAD(FRAME_BAD), .BUS_BYTE_VALID(BUS_BYTE_VALID));
